// >>> capture_if.sv
`timescale 1ns/100ps
interface capture_if;
  import slot_map_pkg::*;
  logic [2:0][6:0] cfg;
  format_t         fmt;
  logic            cfg_tgl;
  logic            cfg_ack_tgl;
  cap_item_t       item;
  logic            cap_tgl;
  logic            cap_ack_tgl;
  logic            drop_tgl;
  modport core (output cfg, fmt, cfg_tgl, cap_ack_tgl, input cfg_ack_tgl, item, cap_tgl, drop_tgl);
  modport link (input cfg, fmt, cfg_tgl, cap_ack_tgl, output cfg_ack_tgl, item, cap_tgl, drop_tgl);
endinterface : capture_if

// >>> frame_source.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Frame source: drives bit clock, frame sync and data.
module frame_source
  import slot_map_pkg::*;
(
  output logic link_bclk,
  output logic link_fsync,
  output logic link_din
);
  initial
  begin
    link_bclk  = 1'b0;
    link_fsync = 1'b0;
    link_din   = 1'b0;
  end
  task automatic pulse(input logic fs, input logic d);
    link_fsync = fs;
    link_din   = d;
    #40 link_bclk = 1'b1;
    #40 link_bclk = 1'b0;
  endtask : pulse
  task automatic idle_clocks(input int n);
    repeat (n) pulse(link_fsync, ~link_din);
  endtask : idle_clocks
  // Slot word of index i is c3 followed by i.
  task automatic send_frame(input format_t fmt);
    logic        fs;
    logic        idle;
    logic [15:0] w;
    int          d;
    idle = (fmt == FMT_I2S);
    repeat (16) pulse(idle, ~link_din);
    for (int c = 0; c < 513; c++)
    begin
      d  = (fmt == FMT_I2S) ? c - 1 : c;
      fs = (fmt == FMT_TDM) ? (c == 0) : ((fmt == FMT_LJ) ? (c < 256) : (c >= 256));
      w  = {8'hc3, 3'h0, d[8:4]};
      pulse(fs, (d >= 0 && d < 512) ? w[15 - d[3:0]] : ~link_din);
    end
    repeat (8) pulse(idle, ~link_din);
  endtask : send_frame
endmodule : frame_source

// >>> link_slot_capture.sv
`timescale 1ns/100ps
`include "slot_map_consts.svh"
module link_slot_capture
  import slot_map_pkg::*;
(
  input  wire logic link_bclk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic link_fsync,
  input  wire logic link_din,
  capture_if.link   cap
);
  logic            rst_s1, rst_s2, ce_s1, ce_s2;
  logic            cfg_s1, cfg_s2, ack_s1, ack_s2;
  logic [2:0][6:0] cfg_live_reg;
  format_t         fmt_live_reg;
  logic            cfg_ack_reg, cap_tgl_reg, drop_tgl_reg;
  cap_item_t       item_reg;
  logic            fs_d_reg, eff_prev_reg, framed_reg, half_reg;
  logic [4:0]      slot_reg;
  logic [3:0]      bit_reg;
  logic [`SLOT_WORD_BITS-2:0] shift_reg;
  logic            eff, start, pos_half, done, fire;
  logic [4:0]      pos_slot, key, hit_slot;
  logic [3:0]      pos_bit;
  logic [2:0]      match;
  logic [1:0]      hit_ch;

  always_ff @(posedge link_bclk)
  begin
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
    ce_s1  <= clk_en;
    ce_s2  <= ce_s1;
  end

  always_ff @(posedge link_bclk)
  begin
    cfg_s1 <= cap.cfg_tgl;
    cfg_s2 <= cfg_s1;
    ack_s1 <= cap.cap_ack_tgl;
    ack_s2 <= ack_s1;
  end

  always_ff @(posedge link_bclk)
  begin
    if (rst_s2)
    begin
      cfg_live_reg <= {7'(`RX_CH8_CFG_RESET), 7'(`RX_CH7_CFG_RESET), 7'(`RX_CH6_CFG_RESET)};
      fmt_live_reg <= FMT_TDM;
      cfg_ack_reg  <= 1'b0;
    end
    else if (ce_s2 && (cfg_s2 != cfg_ack_reg))
    begin
      cfg_live_reg <= cap.cfg;
      fmt_live_reg <= cap.fmt;
      cfg_ack_reg  <= cfg_s2;
    end
  end

  assign eff   = (fmt_live_reg == FMT_I2S) ? fs_d_reg : link_fsync;
  assign start = (fmt_live_reg == FMT_TDM) ? (eff && !eff_prev_reg) : (eff != eff_prev_reg);

  always_comb
  begin
    pos_half = half_reg;
    pos_slot = slot_reg;
    pos_bit  = bit_reg + 1'b1;
    if (start)
    begin
      pos_half = (fmt_live_reg == FMT_I2S) ? eff : !eff;
      pos_slot = 5'h00;
      pos_bit  = 4'h0;
    end
    else if (bit_reg == `SLOT_BIT_LAST)
    begin
      pos_slot = slot_reg + 1'b1;
      pos_bit  = 4'h0;
    end
  end

  assign key  = (fmt_live_reg == FMT_TDM) ? pos_slot : {pos_half, pos_slot[3:0]};
  assign done = (framed_reg || start) && (pos_bit == `SLOT_BIT_LAST);

  for (genvar c = 0; c < 3; c++)
  begin : g_match
    // A channel whose source field is zero never claims a slot.
    assign match[c] = (cfg_live_reg[c][6:5] != SRC_OFF) && (cfg_live_reg[c][4:0] == key)
                      && ((fmt_live_reg == FMT_TDM) || !pos_slot[4]);
  end

  assign hit_ch   = match[0] ? 2'd0 : (match[1] ? 2'd1 : 2'd2);
  assign hit_slot = cfg_live_reg[hit_ch][4:0];
  assign fire     = ce_s2 && done && (match != 3'b000);

  always_ff @(posedge link_bclk)
  begin
    if (rst_s2)
    begin
      fs_d_reg     <= 1'b0;
      eff_prev_reg <= 1'b0;
      framed_reg   <= 1'b0;
      half_reg     <= 1'b0;
      slot_reg     <= 5'h00;
      bit_reg      <= 4'h0;
      shift_reg    <= '0;
    end
    else if (ce_s2)
    begin
      fs_d_reg     <= link_fsync;
      eff_prev_reg <= eff;
      framed_reg   <= framed_reg || start;
      half_reg     <= pos_half;
      slot_reg     <= pos_slot;
      bit_reg      <= pos_bit;
      shift_reg    <= {shift_reg[`SLOT_WORD_BITS-3:0], link_din};
    end
  end

  always_ff @(posedge link_bclk)
  begin
    if (rst_s2)
    begin
      item_reg     <= '0;
      cap_tgl_reg  <= 1'b0;
      drop_tgl_reg <= 1'b0;
    end
    else if (fire && (cap_tgl_reg == ack_s2))
    begin
      item_reg     <= '{src: source_t'(cfg_live_reg[hit_ch][6:5]), chan: hit_ch, data: {shift_reg, link_din}};
      cap_tgl_reg  <= !cap_tgl_reg;
    end
    else if (fire)
    begin
      drop_tgl_reg <= !drop_tgl_reg;
    end
  end

  assign cap.cfg_ack_tgl = cfg_ack_reg;
  assign cap.item        = item_reg;
  assign cap.cap_tgl     = cap_tgl_reg;
  assign cap.drop_tgl    = drop_tgl_reg;

  tdm_slot_a:
    assert property (@(posedge link_bclk) disable iff (rst_s2)
      (fire && (fmt_live_reg == FMT_TDM)) |=> (slot_reg == $past(hit_slot)))
    else $error("TDM capture took a slot other than the programmed one.");

  half_slot_a:
    assert property (@(posedge link_bclk) disable iff (rst_s2)
      (fire && (fmt_live_reg != FMT_TDM)) |=> ({half_reg, slot_reg[3:0]} == $past(hit_slot)) && !slot_reg[4])
    else $error("Two-half capture took the wrong half or slot.");
endmodule : link_slot_capture

// >>> rx_word_fifo.sv
`timescale 1ns/100ps
module rx_word_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready && clk_en;
  assign pop       = out_valid && out_ready && clk_en;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  fifo_no_overflow_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (count_reg == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("Buffer offered space while full.");
endmodule : rx_word_fifo

// >>> secondary_serial_rx_slot_map.sv
`timescale 1ns/100ps
`include "slot_map_consts.svh"
module secondary_serial_rx_slot_map
  import slot_map_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [7:0]             reg_rdata,
  input  slot_map_pkg::format_t  frame_format,
  input  wire logic              link_bclk,
  input  wire logic              link_fsync,
  input  wire logic              link_din,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [15:0]            out_data,
  output logic [3:0]             out_channel,
  output slot_map_pkg::route_t   out_route,
  output logic                   overrun_seen,
  input  wire logic              overrun_clear
);
  import slot_map_pkg::*;

  localparam logic [7:0] CFG_RESET [3] = '{`RX_CH6_CFG_RESET, `RX_CH7_CFG_RESET, `RX_CH8_CFG_RESET};

  capture_if   link_if ();
  logic [6:0]  cfg_reg [3];
  logic [2:0]  wr_sel;
  logic [2:0]  rd_sel;
  logic [2:0][6:0] shadow_reg;
  format_t     fmt_shadow_reg;
  format_t     fmt_seen_reg;
  logic        cfg_tgl_reg;
  logic        dirty_reg;
  logic        cfg_ack_s1, cfg_ack_s2;
  logic        send;
  logic        change;
  logic        cap_s1, cap_s2;
  logic        drop_s1, drop_s2, drop_s3;
  logic        cap_ack_reg;
  xfer_state_t xfer_reg;
  logic        pending;
  logic        push;
  logic        fifo_in_ready;
  cap_item_t   head;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode and storage.

  function automatic logic [2:0] reg_decode(input logic [7:0] addr);
    if (addr == `RX_CH6_CFG_ADDR)
    begin
      return 3'b001;
    end
    else if (addr == `RX_CH7_CFG_ADDR)
    begin
      return 3'b010;
    end
    else if (addr == `RX_CH8_CFG_ADDR)
    begin
      return 3'b100;
    end
    else
    begin
      return 3'b000;
    end
  endfunction : reg_decode

  function automatic route_t decode_route(input logic [1:0] chan, input source_t src);
    route_t r;
    r.kind = src;
    case (src)
      SRC_PLAYBACK: r.number = `RX_CHANNEL_BASE + {2'b00, chan};
      SRC_LOOPBACK: r.number = 4'h2 + {2'b00, chan};
      SRC_LINKED:   r.number = 4'h1 + {2'b00, chan};
      default:      r.number = 4'h0;
    endcase
    return r;
  endfunction : decode_route

  assign wr_sel = reg_write ? reg_decode(reg_addr) : 3'b000;
  assign rd_sel = reg_decode(reg_addr);

  for (genvar c = 0; c < 3; c++)
  begin : g_cfg
    always_ff @(posedge core_clk)
    begin
      if (reset)
      begin
        cfg_reg[c] <= CFG_RESET[c][6:0];
      end
      else if (clk_en && wr_sel[c])
      begin
        cfg_reg[c] <= reg_wdata[`CFG_SRC_MSB:`CFG_SLOT_LSB];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (clk_en && reg_read)
    begin
      if (rd_sel[0])
      begin
        reg_rdata <= {1'b0, cfg_reg[0]};
      end
      else if (rd_sel[1])
      begin
        reg_rdata <= {1'b0, cfg_reg[1]};
      end
      else if (rd_sel[2])
      begin
        reg_rdata <= {1'b0, cfg_reg[2]};
      end
      else
      begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration handed to the link side by a toggle handshake.

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_ack_s1 <= 1'b0;
      cfg_ack_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      cfg_ack_s1 <= link_if.cfg_ack_tgl;
      cfg_ack_s2 <= cfg_ack_s1;
    end
  end

  assign send   = dirty_reg && (cfg_tgl_reg == cfg_ack_s2);
  assign change = (wr_sel != 3'b000) || (frame_format != fmt_seen_reg);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_tgl_reg    <= 1'b0;
      dirty_reg      <= 1'b0;
      fmt_seen_reg   <= FMT_TDM;
      fmt_shadow_reg <= FMT_TDM;
      shadow_reg     <= {CFG_RESET[2][6:0], CFG_RESET[1][6:0], CFG_RESET[0][6:0]};
    end
    else if (clk_en)
    begin
      fmt_seen_reg <= frame_format;
      dirty_reg    <= (dirty_reg && !send) || change;
      if (send)
      begin
        shadow_reg     <= {cfg_reg[2], cfg_reg[1], cfg_reg[0]};
        fmt_shadow_reg <= fmt_seen_reg;
        cfg_tgl_reg    <= !cfg_tgl_reg;
      end
    end
  end

  assign link_if.cfg     = shadow_reg;
  assign link_if.fmt     = fmt_shadow_reg;
  assign link_if.cfg_tgl = cfg_tgl_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Captured words cross back and enter the buffer.

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cap_s1  <= 1'b0;
      cap_s2  <= 1'b0;
      drop_s1 <= 1'b0;
      drop_s2 <= 1'b0;
      drop_s3 <= 1'b0;
    end
    else if (clk_en)
    begin
      cap_s1  <= link_if.cap_tgl;
      cap_s2  <= cap_s1;
      drop_s1 <= link_if.drop_tgl;
      drop_s2 <= drop_s1;
      drop_s3 <= drop_s2;
    end
  end

  assign pending = (cap_s2 != cap_ack_reg);
  assign push    = pending && fifo_in_ready && clk_en;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      xfer_reg    <= XFER_IDLE;
      cap_ack_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      case (xfer_reg)
        XFER_IDLE:
        begin
          if (push)
          begin
            cap_ack_reg <= !cap_ack_reg;
          end
          else if (pending)
          begin
            xfer_reg <= XFER_WAIT;
          end
        end
        XFER_WAIT:
        begin
          if (push)
          begin
            cap_ack_reg <= !cap_ack_reg;
            xfer_reg    <= XFER_IDLE;
          end
        end
        default:
        begin
          xfer_reg <= XFER_IDLE;
        end
      endcase
    end
  end

  assign link_if.cap_ack_tgl = cap_ack_reg;

  // A word that finds the previous word not yet acknowledged by the core side is lost; the set wins over a clear.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      overrun_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      overrun_seen <= (drop_s2 != drop_s3) || (overrun_seen && !overrun_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer, output decode and link side.

  rx_word_fifo #(
    .WIDTH ($bits(cap_item_t)),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (pending),
    .in_ready  (fifo_in_ready),
    .in_data   (link_if.item),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (head)
  );

  assign out_data    = head.data;
  assign out_channel = `RX_CHANNEL_BASE + {2'b00, head.chan};
  assign out_route   = decode_route(head.chan, head.src);

  link_slot_capture u_link (
    .link_bclk  (link_bclk),
    .reset      (reset),
    .clk_en     (clk_en),
    .link_fsync (link_fsync),
    .link_din   (link_din),
    .cap        (link_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  ch6_route_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (out_valid && (head.chan == 2'd0)) |-> (out_channel == 4'h6) && (out_route.kind == head.src)
        && ((head.src != SRC_PLAYBACK) || (out_route.number == 4'h6))
        && ((head.src != SRC_LOOPBACK) || (out_route.number == 4'h2))
        && ((head.src != SRC_LINKED) || (out_route.number == 4'h1)))
    else $error("Channel 6 route decoded wrongly.");

  ch7_route_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (out_valid && (head.chan == 2'd1)) |-> (out_channel == 4'h7)
        && ((head.src != SRC_PLAYBACK) || (out_route.number == 4'h7))
        && ((head.src != SRC_LOOPBACK) || (out_route.number == 4'h3))
        && ((head.src != SRC_LINKED) || (out_route.number == 4'h2)))
    else $error("Channel 7 route decoded wrongly.");

  ch8_route_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (out_valid && (head.chan == 2'd2)) |-> (out_channel == 4'h8)
        && ((head.src != SRC_PLAYBACK) || (out_route.number == 4'h8))
        && ((head.src != SRC_LOOPBACK) || (out_route.number == 4'h4))
        && ((head.src != SRC_LINKED) || (out_route.number == 4'h3)))
    else $error("Channel 8 route decoded wrongly.");

  ch6_write_read_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (clk_en && reg_write && (reg_addr == 8'h2d)) ##1 (clk_en && reg_read && !reg_write && (reg_addr == 8'h2d))
        |=> (reg_rdata[4:0] == $past(reg_wdata[4:0], 2)))
    else $error("Channel 6 slot did not read back as written.");

  reserved_zero_a:
    assert property (@(posedge core_clk) disable iff (reset)
      $changed(reg_rdata) |-> !reg_rdata[7])
    else $error("Reserved bit read as one.");

  ch6_reset_a:
    assert property (@(posedge core_clk)
      reset |=> (cfg_reg[0] == 7'h05) && (reg_rdata == 8'h00))
    else $error("Channel 6 register reset wrongly.");

  ch7_reset_a:
    assert property (@(posedge core_clk)
      reset |=> (cfg_reg[1] == 7'h06) && (cfg_reg[1][4:0] == 5'b00110))
    else $error("Channel 7 register reset wrongly.");

  ch8_reset_a:
    assert property (@(posedge core_clk)
      reset |=> (cfg_reg[2] == 7'h07) && (cfg_reg[2][4:0] == 5'b00111))
    else $error("Channel 8 register reset wrongly.");

  unmapped_read_a:
    assert property (@(posedge core_clk) disable iff (reset)
      (clk_en && reg_read && (reg_decode(reg_addr) == 3'b000)) |=> (reg_rdata == 8'h00))
    else $error("Unmapped address read nonzero.");

  word_out_c:
    cover property (@(posedge core_clk) disable iff (reset) out_valid && out_ready);
  buffer_full_c:
    cover property (@(posedge core_clk) disable iff (reset) pending && !fifo_in_ready);
  overrun_c:
    cover property (@(posedge core_clk) disable iff (reset) $rose(overrun_seen));
  cfg_send_c:
    cover property (@(posedge core_clk) disable iff (reset) send ##[1:40] (cfg_ack_s2 == cfg_tgl_reg));
endmodule : secondary_serial_rx_slot_map

// >>> slot_map_consts.svh
`ifndef SLOT_MAP_CONSTS_SVH
`define SLOT_MAP_CONSTS_SVH
`define RX_CH6_CFG_ADDR  8'h2d
`define RX_CH7_CFG_ADDR  8'h2e
`define RX_CH8_CFG_ADDR  8'h2f
`define RX_CH6_CFG_RESET 8'h05
`define RX_CH7_CFG_RESET 8'h06
`define RX_CH8_CFG_RESET 8'h07
`define CFG_RSVD_BIT     7
`define CFG_SRC_MSB      6
`define CFG_SRC_LSB      5
`define CFG_SLOT_MSB     4
`define CFG_SLOT_LSB     0
`define SLOT_HALF_BIT    4
`define SLOT_WORD_BITS   16
`define SLOT_BIT_LAST    4'hf
`define RX_FIFO_DEPTH    4
`define RX_CHANNEL_BASE  4'h6
`endif

// >>> slot_map_pkg.sv
`include "slot_map_consts.svh"
package slot_map_pkg;
  typedef enum logic [1:0] {
    SRC_OFF      = 2'b00,
    SRC_PLAYBACK = 2'b01,
    SRC_LOOPBACK = 2'b10,
    SRC_LINKED   = 2'b11
  } source_t;
  typedef enum logic [1:0] {
    FMT_TDM = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LJ  = 2'b10
  } format_t;
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_WAIT = 2'b01
  } xfer_state_t;
  typedef struct packed {
    source_t                     kind;
    logic [3:0]                  number;
  } route_t;
  typedef struct packed {
    source_t                     src;
    logic [1:0]                  chan;
    logic [`SLOT_WORD_BITS-1:0]  data;
  } cap_item_t;
endpackage : slot_map_pkg

// >>> tb_secondary_serial_rx_slot_map.sv
`timescale 1ns/100ps
module tb_secondary_serial_rx_slot_map
  import slot_map_pkg::*;
;
  logic        core_clk;
  logic        reset;
  logic        clk_en;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  format_t     frame_format;
  logic        link_bclk;
  logic        link_fsync;
  logic        link_din;
  logic        out_valid;
  logic        out_ready;
  logic [15:0] out_data;
  logic [3:0]  out_channel;
  route_t      out_route;
  logic        overrun_seen;
  logic        overrun_clear;
  logic [25:0] q[$];
  logic [7:0]  d;
  int          mismatches;
  int          samples_checked;
  secondary_serial_rx_slot_map secondary_serial_rx_slot_map_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .frame_format(frame_format), .link_bclk(link_bclk), .link_fsync(link_fsync),
    .link_din(link_din), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_channel(out_channel), .out_route(out_route), .overrun_seen(overrun_seen),
    .overrun_clear(overrun_clear));
  frame_source frame_source_inst (
    .link_bclk(link_bclk), .link_fsync(link_fsync), .link_din(link_din));
  ////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1 && reset === 1'b0)
      q.push_back({out_channel, out_route, out_data});
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #2 {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
    @(posedge core_clk);
    #2 reg_write = 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #2 {reg_addr, reg_read} = {a, 1'b1};
    @(posedge core_clk);
    #2 reg_read = 1'b0;
    v = reg_rdata;
  endtask : read_reg
  task automatic collect(input int n);
    int k;
    k = 0;
    while (q.size() < n && k < 200)
    begin
      @(posedge core_clk);
      k++;
    end
    if (q.size() < n)
    begin
      mismatches++;
      stop_test();
    end
  endtask : collect
  ////////////////////////////////////////////////////////////
  initial
  begin
    {reset, reg_addr, reg_wdata, reg_write, reg_read} = {1'b1, 18'h0};
    {frame_format, out_ready, overrun_clear} = {FMT_TDM, 1'b1, 1'b0};
    clk_en = 1'b1;
    #7;
    fork
      repeat (12) @(posedge core_clk);
      frame_source_inst.idle_clocks(8);
    join
    @(posedge core_clk);
    #2 reset = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      read_reg(8'h2d + i[7:0], d);
      check(d, 8'h05 + i);
    end
    write_reg(8'h2c, 8'h7f);
    read_reg(8'h2c, d);
    check(d, 8'h00);
    $display("test reset_values done");
    #2 clk_en = 1'b0;
    write_reg(8'h2d, 8'h3f);
    #2 clk_en = 1'b1;
    read_reg(8'h2d, d);
    check(d, 8'h05);
    $display("test clock_enable done");
    write_reg(8'h2d, 8'h20);
    write_reg(8'h2e, 8'h5f);
    write_reg(8'h2f, 8'h71);
    read_reg(8'h2d, d);
    check(d, 8'h20);
    #2 out_ready = 1'b0;
    frame_source_inst.send_frame(FMT_TDM);
    repeat (100) @(posedge core_clk);
    #2 check({q.size(), out_valid}, 32'h1);
    out_ready = 1'b1;
    collect(3);
    check(q.pop_front(), {4'h6, 6'h16, 16'hc300});
    check(q.pop_front(), {4'h8, 6'h33, 16'hc311});
    check(q.pop_front(), {4'h7, 6'h23, 16'hc31f});
    $display("test tdm_slots done");
    for (int f = 0; f < 2; f++)
    begin
      #2 frame_format = (f == 0) ? FMT_I2S : FMT_LJ;
      write_reg(8'h2d, 8'h43);
      write_reg(8'h2e, 8'h70);
      write_reg(8'h2f, 8'h05);
      frame_source_inst.send_frame(frame_format);
      collect(2);
      check(q.pop_front(), {4'h6, 6'h22, 16'hc303});
      check(q.pop_front(), {4'h7, 6'h32, 16'hc310});
      repeat (20) @(posedge core_clk);
      check(q.size(), 0);
      $display("test half_slots %0d done", f);
    end
    check(overrun_seen, 1'b0);
    #2 out_ready = 1'b0;
    repeat (3) frame_source_inst.send_frame(FMT_LJ);
    check(overrun_seen, 1'b1);
    @(posedge core_clk);
    #2 overrun_clear = 1'b1;
    @(posedge core_clk);
    #2 overrun_clear = 1'b0;
    check(overrun_seen, 1'b0);
    out_ready = 1'b1;
    collect(5);
    for (int i = 0; i < 5; i++)
    begin
      check(q.pop_front(), (i % 2) ? {4'h7, 6'h32, 16'hc310} : {4'h6, 6'h22, 16'hc303});
    end
    $display("test overrun done");
    stop_test();
  end
endmodule : tb_secondary_serial_rx_slot_map
